/* File: uart_ctl_pkg.sv */
// shared constants, states and carriers of the serial port control block
`default_nettype none
package uart_ctl_pkg;
   // register indices on the plain register port
   localparam logic [2:0] ADDR_CTRL = 3'h0;
   localparam logic [2:0] ADDR_STAT = 3'h1;
   localparam logic [2:0] ADDR_CLR  = 3'h2;
   localparam logic [2:0] ADDR_IEN  = 3'h3;
   localparam logic [2:0] ADDR_DATA = 3'h4;
   localparam logic [2:0] ADDR_BAUD = 3'h5;
   // control register field positions
   localparam int CTRL_MODE = 0;
   localparam int CTRL_MCE  = 1;
   localparam int CTRL_REN  = 2;
   localparam int CTRL_TB9  = 3;
   // status, clear and enable share one layout
   localparam int STAT_TX  = 0;
   localparam int STAT_RX  = 1;
   localparam int STAT_RB9 = 2;
   // divider reset value and index of the last data bit
   localparam logic [7:0] BAUD_RST = 8'h0F;
   localparam logic [2:0] LAST_BIT = 3'h7;

   // frame sequencer states, gray along start-data-ninth-stop
   typedef enum logic [2:0] {
      IDLE  = 3'h0,
      START = 3'h1,
      DATA  = 3'h3,
      NINTH = 3'h2,
      STOP  = 3'h6
   } frame_state_type;

   // frame shape handed to both shifters
   typedef struct packed {
      logic       nine_bit;
      logic [7:0] bit_div;
   } frame_cfg_type;

   // received frame as reported by the receive shifter
   typedef struct packed {
      logic       done;
      logic [7:0] data;
      logic       ninth;
      logic       stop;
   } rx_frame_type;

   // all state of the control block
   typedef struct packed {
      logic       mode;
      logic       multiproc_stop_check;
      logic       rx_enable_bit;
      logic       tx_ninth_bit;
      logic [1:0] ien;
      logic [7:0] baud;
      logic       tx_done_flag;
      logic       rx_done_flag;
      logic       rx_ninth_bit;
      logic [7:0] rx_buf;
      logic       tx_go;
      logic [7:0] tx_byte;
      logic [7:0] rdata;
      logic       irq;
   } ctl_state_type;

   localparam ctl_state_type CTL_RST = '{baud: BAUD_RST, default: '0};
endpackage : uart_ctl_pkg
`default_nettype wire

/* File: serial_tx_shifter.sv */
// transmit shifter: start, eight data bits, optional ninth bit, stop
`timescale 1ns/1ps
`default_nettype none
module serial_tx_shifter (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire uart_ctl_pkg::frame_cfg_type cfg,
   input  wire logic                      start,
   input  wire logic [7:0]                data,
   input  wire logic                      ninth,
   output logic                           txd,
   output logic                           busy,
   output logic                           done
);
   typedef struct packed {
      uart_ctl_pkg::frame_state_type st;
      logic [7:0] cnt;
      logic [2:0] idx;
      logic [7:0] shift;
      logic       nb;
      logic       txd;
      logic       done;
   } tx_state_type;

   tx_state_type s;
   tx_state_type next_s;
   logic         tick;

   // one bit period elapsed
   assign tick = (s.cnt == cfg.bit_div);

   // frame sequencing
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      next_s.cnt = tick ? 8'h00 : s.cnt + 8'h01;
      unique case (s.st)
         uart_ctl_pkg::IDLE: begin
            next_s.cnt = 8'h00;
            next_s.txd = 1'b1;
            if (start) begin
               next_s.st = uart_ctl_pkg::START;
               next_s.shift = data;
               next_s.nb = ninth; // latched so a mid-frame write cannot tear it
               next_s.txd = 1'b0;
            end
         end
         uart_ctl_pkg::START: if (tick) begin
            next_s.st = uart_ctl_pkg::DATA;
            next_s.idx = 3'h0;
            next_s.txd = s.shift[0];
         end
         uart_ctl_pkg::DATA: if (tick) begin
            if (s.idx == uart_ctl_pkg::LAST_BIT) begin
               if (cfg.nine_bit) begin
                  next_s.st = uart_ctl_pkg::NINTH;
                  next_s.txd = s.nb;
               end else begin
                  next_s.st = uart_ctl_pkg::STOP;
                  next_s.txd = 1'b1;
                  next_s.done = 1'b1;
               end
            end else begin
               next_s.idx = s.idx + 3'h1;
               next_s.shift = s.shift >> 1;
               next_s.txd = s.shift[1];
            end
         end
         uart_ctl_pkg::NINTH: if (tick) begin
            next_s.st = uart_ctl_pkg::STOP;
            next_s.txd = 1'b1;
            next_s.done = 1'b1;
         end
         uart_ctl_pkg::STOP: if (tick) next_s.st = uart_ctl_pkg::IDLE;
         default: next_s.st = uart_ctl_pkg::IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '{st: uart_ctl_pkg::IDLE, txd: 1'b1, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign txd  = s.txd;
   assign busy = (s.st != uart_ctl_pkg::IDLE);
   assign done = s.done;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   ninth_level_a: assert property (s.st == uart_ctl_pkg::NINTH |-> txd == s.nb)
      else $error("ninth bit level differs from latched value");
   done_stop_a: assert property (done |-> s.st == uart_ctl_pkg::STOP && s.cnt == 8'h00)
      else $error("transmit done not at start of stop bit");
endmodule : serial_tx_shifter
`default_nettype wire

/* File: serial_rx_shifter.sv */
// receive shifter: samples mid-bit, reports data, ninth and stop levels
`timescale 1ns/1ps
`default_nettype none
module serial_rx_shifter (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire uart_ctl_pkg::frame_cfg_type cfg,
   input  wire logic                        enable,
   input  wire logic                        rxd,
   output var uart_ctl_pkg::rx_frame_type   frame
);
   typedef struct packed {
      uart_ctl_pkg::frame_state_type st;
      logic [7:0] cnt;
      logic [2:0] idx;
      uart_ctl_pkg::rx_frame_type f;
   } rx_state_type;

   rx_state_type s;
   rx_state_type next_s;
   logic         tick;

   assign tick = (s.cnt == cfg.bit_div);

   // start is checked at half a bit, later bits one full period apart
   always_comb begin
      next_s = s;
      next_s.f.done = 1'b0;
      next_s.cnt = tick ? 8'h00 : s.cnt + 8'h01;
      unique case (s.st)
         uart_ctl_pkg::IDLE: begin
            next_s.cnt = 8'h00;
            if (!rxd) next_s.st = uart_ctl_pkg::START;
         end
         uart_ctl_pkg::START: if (s.cnt == {1'b0, cfg.bit_div[7:1]}) begin
            next_s.cnt = 8'h00;
            next_s.idx = 3'h0;
            next_s.st = rxd ? uart_ctl_pkg::IDLE : uart_ctl_pkg::DATA; // glitch rejected
         end
         uart_ctl_pkg::DATA: if (tick) begin
            next_s.f.data = {rxd, s.f.data[7:1]};
            next_s.idx = s.idx + 3'h1;
            if (s.idx == uart_ctl_pkg::LAST_BIT) begin
               next_s.st = cfg.nine_bit ? uart_ctl_pkg::NINTH : uart_ctl_pkg::STOP;
            end
         end
         uart_ctl_pkg::NINTH: if (tick) begin
            next_s.f.ninth = rxd;
            next_s.st = uart_ctl_pkg::STOP;
         end
         uart_ctl_pkg::STOP: if (tick) begin
            next_s.f.stop = rxd;
            next_s.f.done = 1'b1;
            next_s.st = uart_ctl_pkg::IDLE;
         end
         default: next_s.st = uart_ctl_pkg::IDLE;
      endcase
      // a disabled receiver drops any frame in flight
      if (!enable) begin
         next_s.st = uart_ctl_pkg::IDLE;
         next_s.f.done = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '{st: uart_ctl_pkg::IDLE, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign frame = s.f;
endmodule : serial_rx_shifter
`default_nettype wire

/* File: uart_serial_control_bits.sv */
// serial port control and status bits with register port and interrupt
`timescale 1ns/1ps
`default_nettype none
module uart_serial_control_bits (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [7:0]      rdata,
   input  wire logic       rxd,
   output logic            txd,
   output logic            irq
);
   uart_ctl_pkg::ctl_state_type s;
   uart_ctl_pkg::ctl_state_type next_s;
   uart_ctl_pkg::frame_cfg_type cfg;
   uart_ctl_pkg::rx_frame_type  rx_frame;
   logic                        tx_busy;
   logic                        tx_done;
   logic                        rx_ok;
   logic                        clr_tx;
   logic                        clr_rx;

   ////////////////////////////////////////////////////////////////////////
   // register read layout
   function automatic logic [7:0] read_word(
      input uart_ctl_pkg::ctl_state_type r,
      input logic [2:0]                  a
   );
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         uart_ctl_pkg::ADDR_CTRL: begin
            v[uart_ctl_pkg::CTRL_MODE] = r.mode;
            v[uart_ctl_pkg::CTRL_MCE]  = r.multiproc_stop_check;
            v[uart_ctl_pkg::CTRL_REN]  = r.rx_enable_bit;
            v[uart_ctl_pkg::CTRL_TB9]  = r.tx_ninth_bit;
         end
         uart_ctl_pkg::ADDR_STAT: begin
            v[uart_ctl_pkg::STAT_TX]  = r.tx_done_flag;
            v[uart_ctl_pkg::STAT_RX]  = r.rx_done_flag;
            v[uart_ctl_pkg::STAT_RB9] = r.rx_ninth_bit;
         end
         uart_ctl_pkg::ADDR_IEN:  v[1:0] = r.ien;
         uart_ctl_pkg::ADDR_DATA: v = r.rx_buf;
         uart_ctl_pkg::ADDR_BAUD: v = r.baud;
         default: v = 8'h00; // clear register and holes read zero
      endcase
      return v;
   endfunction : read_word

   ////////////////////////////////////////////////////////////////////////
   // frame shifters follow the live mode and divider
   assign cfg.nine_bit = s.mode;
   assign cfg.bit_div  = s.baud;

   serial_tx_shifter serial_tx_shifter_inst (
      .clk   (clk),
      .rst   (rst),
      .cfg   (cfg),
      .start (s.tx_go),
      .data  (s.tx_byte),
      .ninth (s.tx_ninth_bit),
      .txd   (txd),
      .busy  (tx_busy),
      .done  (tx_done)
   );

   serial_rx_shifter serial_rx_shifter_inst (
      .clk    (clk),
      .rst    (rst),
      .cfg    (cfg),
      .enable (s.rx_enable_bit),
      .rxd    (rxd),
      .frame  (rx_frame)
   );

   ////////////////////////////////////////////////////////////////////////
   // frame acceptance: the check bit looks at stop in mode 0, ninth in mode 1
   always_comb begin
      rx_ok = 1'b0;
      if (rx_frame.done && s.rx_enable_bit) begin
         if (!s.multiproc_stop_check) begin
            rx_ok = 1'b1;
         end else if (s.mode) begin
            rx_ok = rx_frame.ninth;
         end else begin
            rx_ok = rx_frame.stop;
         end
      end
   end

   // write-one-to-clear strobes for the sticky flags
   assign clr_tx = wr && (addr == uart_ctl_pkg::ADDR_CLR) && wdata[uart_ctl_pkg::STAT_TX];
   assign clr_rx = wr && (addr == uart_ctl_pkg::ADDR_CLR) && wdata[uart_ctl_pkg::STAT_RX];

   ////////////////////////////////////////////////////////////////////////
   // next state: software writes first, hardware events override
   always_comb begin
      next_s = s;
      next_s.tx_go = 1'b0;
      if (wr) begin
         unique case (addr)
            uart_ctl_pkg::ADDR_CTRL: begin
               next_s.mode                 = wdata[uart_ctl_pkg::CTRL_MODE];
               next_s.multiproc_stop_check = wdata[uart_ctl_pkg::CTRL_MCE];
               next_s.rx_enable_bit        = wdata[uart_ctl_pkg::CTRL_REN];
               next_s.tx_ninth_bit         = wdata[uart_ctl_pkg::CTRL_TB9];
            end
            uart_ctl_pkg::ADDR_IEN:  next_s.ien = wdata[1:0];
            uart_ctl_pkg::ADDR_BAUD: next_s.baud = wdata;
            uart_ctl_pkg::ADDR_DATA: begin
               // a write during a frame is dropped rather than corrupting it
               if (!tx_busy && !s.tx_go) begin
                  next_s.tx_go = 1'b1;
                  next_s.tx_byte = wdata;
               end
            end
            default: begin
            end
         endcase
      end
      if (clr_tx) next_s.tx_done_flag = 1'b0;
      if (clr_rx) next_s.rx_done_flag = 1'b0;
      // the set wins over a clear in the same cycle
      if (tx_done) next_s.tx_done_flag = 1'b1;
      if (rx_ok) begin
         next_s.rx_done_flag = 1'b1;
         next_s.rx_buf = rx_frame.data;
         next_s.rx_ninth_bit = s.mode ? rx_frame.ninth : rx_frame.stop;
      end
      next_s.rdata = rd ? read_word(s, addr) : 8'h00;
      next_s.irq = |(next_s.ien & {next_s.rx_done_flag, next_s.tx_done_flag});
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= uart_ctl_pkg::CTL_RST;
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;
   assign irq   = s.irq;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   stop_check_gate_a: assert property (
      rx_frame.done && s.rx_enable_bit && !s.mode && s.multiproc_stop_check
      && !rx_frame.stop && !s.rx_done_flag |=> !s.rx_done_flag)
      else $error("receive flag set on a zero stop bit");
   ninth_check_gate_a: assert property (
      rx_frame.done && s.rx_enable_bit && s.mode && s.multiproc_stop_check
      && !rx_frame.ninth && !s.rx_done_flag |=> !s.rx_done_flag)
      else $error("receive flag set on a zero ninth bit");
   rx_disabled_a: assert property (!s.rx_enable_bit |=> !rx_frame.done)
      else $error("frame completed while receiver disabled");
   rx_ninth_field_a: assert property (
      rx_ok |=> s.rx_ninth_bit == ($past(s.mode) ? $past(rx_frame.ninth) : $past(rx_frame.stop)))
      else $error("received ninth field holds the wrong level");
   tx_flag_hold_a: assert property (
      s.tx_done_flag && !clr_tx |=> s.tx_done_flag)
      else $error("transmit done flag cleared without software");
   rx_flag_set_a: assert property (rx_ok |=> s.rx_done_flag && s.rx_buf == $past(rx_frame.data))
      else $error("receive flag or data missing after stop sample");
   rx_flag_hold_a: assert property (
      s.rx_done_flag && !clr_rx |=> s.rx_done_flag)
      else $error("receive flag cleared without software");
   tx_flag_set_a: assert property (tx_done |=> s.tx_done_flag)
      else $error("transmit done flag not set at stop bit");
   irq_follow_a: assert property (
      $rose(s.tx_done_flag) && s.ien[uart_ctl_pkg::STAT_TX] && $stable(s.ien) |-> irq)
      else $error("enabled transmit done raised no interrupt");
   read_timing_a: assert property (!rd |=> rdata == 8'h00)
      else $error("read data outside the answer cycle");

   accept_nine_c: cover property (rx_ok && s.mode && s.multiproc_stop_check);
   reject_stop_c: cover property (rx_frame.done && !rx_ok && !s.mode);
   tx_done_c:     cover property (tx_done && s.mode);
   irq_rise_c:    cover property ($rose(irq));
endmodule : uart_serial_control_bits
`default_nettype wire

/* File: remote_serial_end.sv */
// far-side serial end: sends frames to the block and decodes the frames it sends
`timescale 1ns/1ps
`default_nettype none
module remote_serial_end #(
   parameter int BIT_CLKS = 4
) (
   input  wire logic       clk,
   input  wire logic       txd,
   input  wire logic       nine,
   output logic            rxd,
   output logic [7:0]      got_byte,
   output logic            got_ninth,
   output logic            got_stop,
   output int              got_count
);
   // idle line is high, nothing decoded yet
   initial begin
      rxd       = 1'b1;
      got_byte  = 8'h00;
      got_ninth = 1'b0;
      got_stop  = 1'b0;
      got_count = 0;
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // one bit held for a whole bit period; call only right after a rising edge
   task automatic put_bit(input logic b);
      rxd <= b;
      repeat (BIT_CLKS) @(posedge clk);
   endtask : put_bit

   // start, data lsb first, optional ninth, stop, then a short idle gap
   task automatic send_frame(input logic [7:0] data, input logic with_ninth,
                             input logic ninth, input logic stop);
      int i;
      put_bit(1'b0);
      for (i = 0; i < 8; i++) begin
         put_bit(data[i]);
      end
      if (with_ninth) begin
         put_bit(ninth);
      end
      put_bit(stop);
      repeat (3) put_bit(1'b1);
   endtask : send_frame

   ////////////////////////////////////////////////////////////////////////////////////////
   // line decoder: samples mid-bit so edges of the block's line never race the sample
   always begin : decode
      logic [9:0] sh;
      int         i;
      int         nb;
      @(negedge txd);
      nb = nine ? 10 : 9;
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (i = 0; i < nb; i++) begin
         repeat (BIT_CLKS) @(posedge clk);
         sh[i] = txd;
      end
      got_byte  <= sh[7:0];
      got_ninth <= nine ? sh[8] : 1'b0;
      got_stop  <= nine ? sh[9] : sh[8];
      got_count <= got_count + 1;
   end
endmodule : remote_serial_end
`default_nettype wire

/* File: test_uart_serial_control_bits.sv */
// self-checking bench of the serial port control and status bits
`timescale 1ns/1ps
`default_nettype none
module test_uart_serial_control_bits;
   // row fields: mode, check bit, ninth sent, stop sent, frame accepted
   typedef struct packed {
      logic mode;
      logic mce;
      logic ninth;
      logic stop;
      logic acc;
   } row_type;
   localparam row_type ROWS [7] = '{5'h01, 5'h03, 5'h08, 5'h0B, 5'h13, 5'h1A, 5'h1F};
   localparam logic [7:0] BAUD_FAST = 8'h03;
   logic       clk;
   logic       rst;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       rxd;
   logic       txd;
   logic       irq;
   logic       nine;
   logic [7:0] got_byte;
   logic       got_ninth;
   logic       got_stop;
   int         got_count;
   int         fails;
   int         n_tests;
   logic [7:0] v;
   logic       exp_rb9;
   logic [7:0] exp_data;
   logic [1:0] tb9_mode;
   int         i;
   int         cnt;
   int         seen;

   uart_serial_control_bits uart_serial_control_bits_inst (
      .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .rxd(rxd), .txd(txd), .irq(irq));
   remote_serial_end #(.BIT_CLKS(int'(BAUD_FAST) + 1)) remote_serial_end_inst (
      .clk(clk), .txd(txd), .nine(nine), .rxd(rxd), .got_byte(got_byte),
      .got_ninth(got_ninth), .got_stop(got_stop), .got_count(got_count));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // one comparison, case inequality so an unknown never passes
   task automatic check(input string what, input logic [7:0] seen_v, input logic [7:0] exp);
      n_tests++;
      if (seen_v !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen_v);
      end
   endtask : check

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize

   // single-cycle write strobe, taken at the edge where the task returns
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe is taken
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   ////////////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst   = 1'b1;
      addr  = 3'h0;
      wdata = 8'h00;
      wr    = 1'b0;
      rd    = 1'b0;
      nine  = 1'b0;
      fails = 0;
      n_tests = 0;
      exp_rb9 = 1'b0;
      exp_data = 8'h00;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      // reset values, read-only status, unmapped index
      rd_reg(uart_ctl_pkg::ADDR_CTRL, v);
      check("ctrl", v, 8'h00);
      rd_reg(uart_ctl_pkg::ADDR_IEN, v);
      check("ien", v, 8'h00);
      rd_reg(uart_ctl_pkg::ADDR_BAUD, v);
      check("baud", v, 8'h0F);
      wr_reg(uart_ctl_pkg::ADDR_STAT, 8'hFF);
      rd_reg(uart_ctl_pkg::ADDR_STAT, v);
      check("stat", v, 8'h00);
      rd_reg(3'h7, v);
      check("unmapped", v, 8'h00);
      check("txd idle", {7'h00, txd}, 8'h01);
      wr_reg(uart_ctl_pkg::ADDR_BAUD, BAUD_FAST);
      rd_reg(uart_ctl_pkg::ADDR_BAUD, v);
      check("baud", v, BAUD_FAST);
      $display("reset test done");

      // receiver off: a frame leaves no trace
      wr_reg(uart_ctl_pkg::ADDR_IEN, 8'h02);
      wr_reg(uart_ctl_pkg::ADDR_CTRL, 8'h00);
      remote_serial_end_inst.send_frame(8'h3C, 1'b0, 1'b0, 1'b1);
      rd_reg(uart_ctl_pkg::ADDR_STAT, v);
      check("rx off flag", {7'h00, v[uart_ctl_pkg::STAT_RX]}, 8'h00);
      check("rx off irq", {7'h00, irq}, 8'h00);
      $display("receiver off test done");

      // receive rows: every mode against the check bit and the received levels
      for (i = 0; i < 7; i++) begin
         wr_reg(uart_ctl_pkg::ADDR_CTRL, {5'h00, 1'b1, ROWS[i].mce, ROWS[i].mode});
         wr_reg(uart_ctl_pkg::ADDR_CLR, 8'h03);
         @(posedge clk);
         remote_serial_end_inst.send_frame(8'h5A + 8'(i), ROWS[i].mode, ROWS[i].ninth,
                                           ROWS[i].stop);
         if (ROWS[i].acc) begin
            exp_rb9 = ROWS[i].mode ? ROWS[i].ninth : ROWS[i].stop;
            exp_data = 8'h5A + 8'(i);
         end
         rd_reg(uart_ctl_pkg::ADDR_STAT, v);
         check("rx flag", {7'h00, v[uart_ctl_pkg::STAT_RX]}, {7'h00, ROWS[i].acc});
         check("rx ninth", {7'h00, v[uart_ctl_pkg::STAT_RB9]}, {7'h00, exp_rb9});
         check("rx irq", {7'h00, irq}, {7'h00, ROWS[i].acc});
         // a refused frame must leave the buffer as the last accepted one left it
         rd_reg(uart_ctl_pkg::ADDR_DATA, v);
         check("rx data", v, exp_data);
         // a broken stop bit may start a phantom frame; let it run out
         repeat (60) @(posedge clk);
         $display("receive row %0d done", i);
      end

      // transmit: 8-bit with ninth set, 9-bit with ninth clear and set
      for (i = 0; i < 3; i++) begin
         tb9_mode = (i == 0) ? 2'h2 : ((i == 1) ? 2'h1 : 2'h3);
         nine <= tb9_mode[0];
         wr_reg(uart_ctl_pkg::ADDR_CTRL, {4'h0, tb9_mode[1], 2'h0, tb9_mode[0]});
         wr_reg(uart_ctl_pkg::ADDR_CLR, 8'h03);
         wr_reg(uart_ctl_pkg::ADDR_IEN, 8'h01);
         seen = got_count;
         wr_reg(uart_ctl_pkg::ADDR_DATA, 8'hA5 - 8'(i));
         cnt = 0;
         while (irq !== 1'b1 && cnt < 300) begin
            @(posedge clk);
            #1;
            cnt++;
         end
         if (tb9_mode[0]) begin
            check("tx done time", {7'h00, 1'(cnt >= 40 && cnt <= 45)}, 8'h01);
         end else begin
            check("tx done time", {7'h00, 1'(cnt >= 36 && cnt <= 41)}, 8'h01);
         end
         cnt = 0;
         while (got_count == seen && cnt < 40) begin
            @(posedge clk);
            cnt++;
         end
         check("tx frame seen", {7'h00, 1'(got_count != seen)}, 8'h01);
         check("tx byte", got_byte, 8'hA5 - 8'(i));
         check("tx ninth", {7'h00, got_ninth}, {7'h00, tb9_mode[0] & tb9_mode[1]});
         check("tx stop", {7'h00, got_stop}, 8'h01);
         repeat (40) @(posedge clk);
         rd_reg(uart_ctl_pkg::ADDR_STAT, v);
         check("tx flag held", {7'h00, v[uart_ctl_pkg::STAT_TX]}, 8'h01);
         check("tx irq held", {7'h00, irq}, 8'h01);
         wr_reg(uart_ctl_pkg::ADDR_CLR, 8'h01);
         rd_reg(uart_ctl_pkg::ADDR_STAT, v);
         check("tx flag clear", {7'h00, v[uart_ctl_pkg::STAT_TX]}, 8'h00);
         check("tx irq clear", {7'h00, irq}, 8'h00);
         $display("transmit case %0d done", i);
      end

      // second reset in mid-run clears control and enables
      wr_reg(uart_ctl_pkg::ADDR_CTRL, 8'h0F);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_reg(uart_ctl_pkg::ADDR_CTRL, v);
      check("ctrl after reset", v, 8'h00);
      rd_reg(uart_ctl_pkg::ADDR_IEN, v);
      check("ien after reset", v, 8'h00);
      check("irq after reset", {7'h00, irq}, 8'h00);
      $display("second reset test done");
      summarize();
   end
endmodule : test_uart_serial_control_bits
`default_nettype wire
